// [hw/tks_setup_regs.sv]
// Setup register bank of a matrix touch-key controller, with decoded configuration.
// Assumes a plain register port on clk; key samples arrive on clk; sync pin is asynchronous.
//
// Overview of operation
// - Threshold byte: low nibble negative, high nibble positive, each plus four.
// - Drift byte: low nibble negative rate, high nibble positive rate, via table.
// - Normal integrator limit is the low nibble; zero disables bursting.
// - Timeout in half seconds, zero infinite, default 20, 255 forbidden.
// - Timing low nibble selects sample period via table, default code 6.
// - Timing bits 5:4 select burst length via table, default 48.
// - Timing bit 6 enables neighbour-key suppression.
// - Signal offset byte is passed to the measurement.
// - Options bits 1:0 select negative hysteresis, default 12.5 percent.
// - Options bit 5 syncs acquisition to mains falling edge.
// - Options bits 4:2 set sleep drift rate; zero disables sleep.
// - Options bits 7:6 select threshold multiplier; zero means one.
// - Dwell low nibble picks one of sixteen dwell times, default 188 ns.
// - Dwell high nibble picks UART rate, 9600 to 115200 baud.
// - Limit bits 10:0 are signal floor; below it an error flags.
// - Limit bit 11 enables restart of interrupted bursts.
// - Limit bits 15:12 select gain test threshold, default 32 counts.
`timescale 1ns/1ps
module tks_setup_regs (
  input wire logic clk, // 200 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] addr, // Register index
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic [10:0] key_sig, // Measured key signal
  input wire logic key_sig_vld, // Key signal valid
  input wire logic mains_sync, // Mains sync pin
  output logic sig_low, // Pulse: signal below floor
  output logic acq_go, // Acquisition may proceed
  output tks_pkg::tks_cfg_t cfg // Decoded setups
);
  import tks_pkg::*;

  tks_state_t st_r;
  tks_state_t st_nxt;
  logic mains_fall;

  tks_fall_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(mains_sync),
    .fall(mains_fall)
  );

  function automatic logic [7:0] drift_lut(input logic [3:0] c);
    drift_lut = {c, 4'h0} + 8'h10;
  endfunction

  function automatic logic [15:0] period_lut(input logic [3:0] c);
    case (c)
      4'h0: period_lut = 16'h000a;
      4'h1: period_lut = 16'h0019;
      4'h2: period_lut = 16'h0032;
      4'h3: period_lut = 16'h0064;
      4'h4: period_lut = 16'h00fa;
      4'h5: period_lut = 16'h01f4;
      4'h6: period_lut = 16'h03e8;
      4'h7: period_lut = 16'h07d0;
      default: period_lut = 16'h0fa0;
    endcase
  endfunction

  function automatic logic [7:0] burst_lut(input logic [1:0] c);
    case (c)
      2'h0: burst_lut = 8'h10;
      2'h1: burst_lut = 8'h20;
      2'h2: burst_lut = 8'h30;
      default: burst_lut = 8'h40;
    endcase
  endfunction

  function automatic logic [9:0] hyst_lut(input logic [1:0] c);
    case (c)
      2'h0: hyst_lut = 10'h07d;
      2'h1: hyst_lut = 10'h0fa;
      2'h2: hyst_lut = 10'h177;
      default: hyst_lut = 10'h1f4;
    endcase
  endfunction

  function automatic logic [15:0] dwell_lut(input logic [3:0] c);
    case (c)
      4'h0: dwell_lut = 16'h007d;
      4'hf: dwell_lut = 16'h0bb8;
      default: dwell_lut = 16'h00bc + {6'h00, c - 4'h1, 6'h00};
    endcase
  endfunction

  function automatic logic [16:0] baud_lut(input logic [3:0] c);
    case (c)
      4'h0: baud_lut = 17'h02580;
      4'h1: baud_lut = 17'h04b00;
      4'h2: baud_lut = 17'h09600;
      4'h3: baud_lut = 17'h0e100;
      default: baud_lut = 17'h1c200;
    endcase
  endfunction

  function automatic logic [7:0] gain_test_lut(input logic [3:0] c);
    gain_test_lut = {2'h0, c, 2'h0} + 8'h04;
  endfunction

  function automatic tks_cfg_t decode(input tks_state_t s);
    tks_cfg_t c;
    c.neg_thresh = {1'b0, s.thresh[3:0]} + TKS_THR_ADD;
    c.pos_thresh = {1'b0, s.thresh[7:4]} + TKS_THR_ADD;
    c.neg_drift = drift_lut(s.drift[3:0]);
    c.pos_drift = drift_lut(s.drift[7:4]);
    c.detect_integrator_norm = s.integ[3:0];
    c.burst_disable = (s.integ[3:0] == 4'h0);
    c.detect_integrator_fast = s.integ[7:4];
    c.recal_timeout = s.recal;
    c.recal_infinite = (s.recal == 8'h00);
    c.sample_period_ms = period_lut(s.timing[3:0]);
    c.burst_length = burst_lut(s.timing[TKS_TIM_BURST_LSB +: 2]);
    c.neighbor_key_suppress = s.timing[TKS_TIM_SUPPRESS_BIT];
    c.signal_offset = s.offset;
    c.neg_hyst_pct_x10 = hyst_lut(s.options[1:0]);
    c.mains_sync_en = s.options[TKS_OPT_SYNC_BIT];
    c.sleep_drift = s.options[TKS_OPT_SLEEP_LSB +: 3];
    c.sleep_en = (s.options[TKS_OPT_SLEEP_LSB +: 3] != 3'h0);
    c.thresh_mult = 4'h1 << s.options[TKS_OPT_MULT_LSB +: 2];
    c.dwell_ns = dwell_lut(s.dwell[3:0]);
    c.baud = baud_lut(s.dwell[7:4]);
    c.signal_floor = s.floor[10:0];
    c.restart_burst = s.floor[TKS_LIM_RESTART_BIT];
    c.key_gain_test_threshold = gain_test_lut(s.floor[TKS_LIM_GAIN_LSB +: 4]);
    decode = c;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    st_nxt.sig_low = 1'b0;
    st_nxt.run = 1'b1;
    if (wr) begin
      case (addr)
        TKS_OFS_THRESH: st_nxt.thresh = wdata;
        TKS_OFS_DRIFT: st_nxt.drift = wdata;
        TKS_OFS_INTEG: begin
          if (wdata[7:4] == 4'h0) begin
            st_nxt.err_illegal = 1'b1;
          end else begin
            st_nxt.integ = wdata;
          end
        end
        TKS_OFS_RECAL: begin
          if (wdata == TKS_RECAL_ILLEGAL) begin
            st_nxt.err_illegal = 1'b1;
          end else begin
            st_nxt.recal = wdata;
          end
        end
        TKS_OFS_TIMING: st_nxt.timing = wdata;
        TKS_OFS_OFFSET: st_nxt.offset = wdata;
        TKS_OFS_OPTIONS: st_nxt.options = wdata;
        TKS_OFS_DWELL: st_nxt.dwell = wdata;
        TKS_OFS_FLOOR_LO: begin
          st_nxt.stage = wdata;
          st_nxt.stage_vld = 1'b1;
        end
        TKS_OFS_FLOOR_HI: begin
          st_nxt.floor = {wdata, st_r.stage_vld ? st_r.stage : st_r.floor[7:0]};
          st_nxt.stage_vld = 1'b0;
        end
        TKS_OFS_STATUS: begin
          st_nxt.err_low = st_r.err_low & ~wdata[TKS_ST_LOW_BIT];
          st_nxt.err_illegal = st_r.err_illegal & ~wdata[TKS_ST_ILL_BIT];
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (key_sig_vld && (key_sig < st_r.floor[10:0])) begin
      st_nxt.sig_low = 1'b1;
      st_nxt.err_low = 1'b1;
    end
    if (rd) begin
      case (addr)
        TKS_OFS_THRESH: st_nxt.rdata = st_r.thresh;
        TKS_OFS_DRIFT: st_nxt.rdata = st_r.drift;
        TKS_OFS_INTEG: st_nxt.rdata = st_r.integ;
        TKS_OFS_RECAL: st_nxt.rdata = st_r.recal;
        TKS_OFS_TIMING: st_nxt.rdata = st_r.timing;
        TKS_OFS_OFFSET: st_nxt.rdata = st_r.offset;
        TKS_OFS_OPTIONS: st_nxt.rdata = st_r.options;
        TKS_OFS_DWELL: st_nxt.rdata = st_r.dwell;
        TKS_OFS_FLOOR_LO: st_nxt.rdata = st_r.floor[7:0];
        TKS_OFS_FLOOR_HI: st_nxt.rdata = st_r.floor[15:8];
        TKS_OFS_STATUS: st_nxt.rdata = {5'h00, st_r.stage_vld, st_r.err_illegal, st_r.err_low};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.acq_go = st_r.run & (~st_r.cfg.mains_sync_en | mains_fall);
    st_nxt.cfg = decode(st_nxt);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.thresh <= TKS_RST_THRESH;
      st_r.drift <= TKS_RST_DRIFT;
      st_r.integ <= TKS_RST_INTEG;
      st_r.recal <= TKS_RST_RECAL;
      st_r.timing <= TKS_RST_TIMING;
      st_r.offset <= TKS_RST_OFFSET;
      st_r.options <= TKS_RST_OPTIONS;
      st_r.dwell <= TKS_RST_DWELL;
      st_r.floor <= TKS_RST_FLOOR;
      st_r.cfg.neg_thresh <= 5'h0a;
      st_r.cfg.pos_thresh <= 5'h0a;
      st_r.cfg.neg_drift <= 8'h30;
      st_r.cfg.pos_drift <= 8'h30;
      st_r.cfg.detect_integrator_norm <= 4'h2;
      st_r.cfg.detect_integrator_fast <= 4'h2;
      st_r.cfg.recal_timeout <= TKS_RST_RECAL;
      st_r.cfg.sample_period_ms <= 16'h03e8;
      st_r.cfg.burst_length <= 8'h30;
      st_r.cfg.neg_hyst_pct_x10 <= 10'h07d;
      st_r.cfg.thresh_mult <= 4'h1;
      st_r.cfg.dwell_ns <= 16'h00bc;
      // Rate code 0 of the dwell reset byte
      st_r.cfg.baud <= 17'h02580;
      st_r.cfg.signal_floor <= 11'h000;
      st_r.cfg.key_gain_test_threshold <= 8'h20;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign sig_low = st_r.sig_low;
  assign acq_go = st_r.acq_go;
  assign cfg = st_r.cfg;

  a_thresh_offset: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.neg_thresh == {1'b0, st_r.thresh[3:0]} + TKS_THR_ADD && cfg.pos_thresh == {1'b0, st_r.thresh[7:4]} + 5'h04)
    else $error("threshold not nibble plus four");

  a_drift_follow: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_DRIFT |=> cfg.pos_drift == drift_lut($past(wdata[7:4])))
    else $error("drift rate not updated from write");

  a_burst_off: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.burst_disable == (cfg.detect_integrator_norm == 4'h0))
    else $error("burst disable mismatch");

  a_fast_zero_ref: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_INTEG && wdata[7:4] == 4'h0 |=> st_r.err_illegal && $stable(st_r.integ))
    else $error("zero fast limit accepted");

  a_timeout_legal: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.recal_timeout != TKS_RECAL_ILLEGAL && cfg.recal_infinite == (cfg.recal_timeout == 8'h00))
    else $error("timeout holds forbidden value");

  a_period_code: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.timing[3:0] == 4'h6 |-> cfg.sample_period_ms == 16'h03e8)
    else $error("period code 6 not one second");

  a_burst_48: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.timing[5:4] == 2'h2 |-> cfg.burst_length == 8'h30)
    else $error("burst setting 2 not 48");

  a_mains_gate: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.mains_sync_en && !mains_fall |=> !acq_go)
    else $error("acquisition ran without mains edge");

  a_floor_flag: assert property (@(posedge clk) disable iff (!rst_n)
    key_sig_vld && key_sig < cfg.signal_floor |=> sig_low && st_r.err_low)
    else $error("low signal not flagged");

  a_floor_atomic: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_FLOOR_LO |=> $stable(st_r.floor) && st_r.stage_vld)
    else $error("floor changed on low byte");

  a_gain_test_32: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.floor[15:12] == 4'h7 |-> cfg.key_gain_test_threshold == 8'h20)
    else $error("gain test code 7 not 32");

  a_read_one: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data outside read slot");

  a_suppress_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_TIMING |=> cfg.neighbor_key_suppress == $past(wdata[TKS_TIM_SUPPRESS_BIT]))
    else $error("suppress bit not taken from write");

  a_offset_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_OFFSET |=> cfg.signal_offset == $past(wdata))
    else $error("offset not passed through");

  a_hyst_default: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.options[1:0] == 2'h0 |-> cfg.neg_hyst_pct_x10 == 10'h07d)
    else $error("hysteresis code 0 not 12.5 percent");

  a_sleep_off: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_OPTIONS && wdata[TKS_OPT_SLEEP_LSB +: 3] == 3'h0 |=> !cfg.sleep_en)
    else $error("sleep left on with zero rate");

  a_mult_one: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.options[TKS_OPT_MULT_LSB +: 2] == 2'h0 |-> cfg.thresh_mult == 4'h1)
    else $error("multiplier code 0 not one");

  a_dwell_188: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.dwell[3:0] == 4'h1 |-> cfg.dwell_ns == 16'h00bc)
    else $error("dwell code 1 not 188 ns");

  a_baud_range: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.baud >= 17'h02580 && cfg.baud <= 17'h1c200)
    else $error("UART rate outside range");

  a_restart_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == TKS_OFS_FLOOR_HI |=> cfg.restart_burst == $past(wdata[TKS_LIM_RESTART_BIT - 8]))
    else $error("restart bit not taken from high byte");

  a_no_early_go: assert property (@(posedge clk) disable iff (!rst_n)
    !st_r.run |=> !acq_go)
    else $error("acquisition before defaults loaded");

endmodule

// [inc/tks_pkg.sv]
// Package for the touch-key setup register bank: offsets, field layout, reset values, types.
// Assumes one 200 MHz clock and an 8-bit register port with a 4-bit register index.
package tks_pkg;

  localparam int TKS_AW = 4;
  localparam int TKS_CLK_MHZ = 200;

  // Register indices on the plain port
  localparam logic [3:0] TKS_OFS_THRESH = 4'h0;
  localparam logic [3:0] TKS_OFS_DRIFT = 4'h1;
  localparam logic [3:0] TKS_OFS_INTEG = 4'h2;
  localparam logic [3:0] TKS_OFS_RECAL = 4'h3;
  localparam logic [3:0] TKS_OFS_TIMING = 4'h4;
  localparam logic [3:0] TKS_OFS_OFFSET = 4'h5;
  localparam logic [3:0] TKS_OFS_OPTIONS = 4'h6;
  localparam logic [3:0] TKS_OFS_DWELL = 4'h7;
  localparam logic [3:0] TKS_OFS_FLOOR_LO = 4'h8;
  localparam logic [3:0] TKS_OFS_FLOOR_HI = 4'h9;
  localparam logic [3:0] TKS_OFS_STATUS = 4'ha;

  // Values after reset
  localparam logic [7:0] TKS_RST_THRESH = 8'h66;
  localparam logic [7:0] TKS_RST_DRIFT = 8'h22;
  localparam logic [7:0] TKS_RST_INTEG = 8'h22;
  localparam logic [7:0] TKS_RST_RECAL = 8'h14;
  localparam logic [7:0] TKS_RST_TIMING = 8'h26;
  localparam logic [7:0] TKS_RST_OFFSET = 8'h00;
  localparam logic [7:0] TKS_RST_OPTIONS = 8'h00;
  localparam logic [7:0] TKS_RST_DWELL = 8'h01;
  localparam logic [15:0] TKS_RST_FLOOR = 16'h7000;

  // Field layout
  localparam logic [4:0] TKS_THR_ADD = 5'h04;
  localparam int TKS_TIM_BURST_LSB = 4;
  localparam int TKS_TIM_SUPPRESS_BIT = 6;
  localparam int TKS_OPT_SLEEP_LSB = 2;
  localparam int TKS_OPT_SYNC_BIT = 5;
  localparam int TKS_OPT_MULT_LSB = 6;
  localparam int TKS_LIM_RESTART_BIT = 11;
  localparam int TKS_LIM_GAIN_LSB = 12;
  localparam logic [7:0] TKS_RECAL_ILLEGAL = 8'hff;
  localparam int TKS_ST_LOW_BIT = 0;
  localparam int TKS_ST_ILL_BIT = 1;
  localparam int TKS_ST_STAGE_BIT = 2;

  typedef struct packed {
    logic [4:0] neg_thresh;
    logic [4:0] pos_thresh;
    logic [7:0] neg_drift;
    logic [7:0] pos_drift;
    logic [3:0] detect_integrator_norm;
    logic [3:0] detect_integrator_fast;
    logic burst_disable;
    logic [7:0] recal_timeout;
    logic recal_infinite;
    logic [15:0] sample_period_ms;
    logic [7:0] burst_length;
    logic neighbor_key_suppress;
    logic [7:0] signal_offset;
    logic [9:0] neg_hyst_pct_x10;
    logic mains_sync_en;
    logic [2:0] sleep_drift;
    logic sleep_en;
    logic [3:0] thresh_mult;
    logic [15:0] dwell_ns;
    logic [16:0] baud;
    logic [10:0] signal_floor;
    logic restart_burst;
    logic [7:0] key_gain_test_threshold;
  } tks_cfg_t;

  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] drift;
    logic [7:0] integ;
    logic [7:0] recal;
    logic [7:0] timing;
    logic [7:0] offset;
    logic [7:0] options;
    logic [7:0] dwell;
    logic [15:0] floor;
    logic [7:0] stage;
    logic stage_vld;
    logic err_low;
    logic err_illegal;
    logic [7:0] rdata;
    logic sig_low;
    logic run;
    logic acq_go;
    tks_cfg_t cfg;
  } tks_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tks_sync_t;

endpackage

// [hw/tks_fall_sync.sv]
// Two-flop synchroniser with falling-edge pulse for the mains sync pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module tks_fall_sync (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic pin, // Raw pin level
  output logic fall // One-cycle pulse on falling edge
);
  import tks_pkg::*;

  tks_sync_t st_r;
  tks_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fall = st_r.s3 & ~st_r.s2;

endmodule

// [sim/tks_host_model.sv]
// Host-side bus master for the setup registers: write, read and paired floor write.
// Assumes the plain register port on clk; data are taken in the cycle after rd.
`timescale 1ns/1ps
module tks_host_model (
  input wire logic clk, // 200 MHz clock
  output logic [3:0] addr, // Register index
  output logic [7:0] wdata, // Write data
  output logic wr, // Write strobe
  output logic rd, // Read strobe
  input wire logic [7:0] rdata // Read data
);
  import tks_pkg::*;

  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic write_reg(input logic [3:0] a, input logic [7:0] d, input bit bad);
    if (!bad && ((a == TKS_OFS_INTEG && d[7:4] == 4'h0) || (a == TKS_OFS_RECAL && d == TKS_RECAL_ILLEGAL)))
      return;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic write_floor(input logic [15:0] f);
    write_reg(TKS_OFS_FLOOR_LO, f[7:0], 1'b0);
    write_reg(TKS_OFS_FLOOR_HI, f[15:8], 1'b0);
  endtask
endmodule

// [sim/touch_sensor_setup_params_tb.sv]
// Self-checking bench for the setup register bank, with a register model in the bench.
// Assumes the host model drives the register port; key signal and sync pin come from here.
`timescale 1ns/1ps
module touch_sensor_setup_params_tb;
  import tks_pkg::*;
  logic clk, rst_n, wr, rd, key_sig_vld, mains_sync, sig_low, acq_go;
  logic [3:0] addr, a;
  logic [7:0] wdata, rdata, d;
  logic [10:0] key_sig;
  logic [15:0] fl;
  logic [7:0] m [0:7];
  tks_cfg_t cfg;
  int bad_count, n_checks, seed, v, w;

  tks_setup_regs i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .key_sig(key_sig), .key_sig_vld(key_sig_vld), .mains_sync(mains_sync),
    .sig_low(sig_low), .acq_go(acq_go), .cfg(cfg));
  tks_host_model i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic int dwl(input int c);
    return c == 0 ? 125 : (c == 15 ? 3000 : 188 + 64 * (c - 1));
  endfunction

  function automatic int bd(input int c);
    int t [0:4] = '{9600, 19200, 38400, 57600, 115200};
    return c > 4 ? 115200 : t[c];
  endfunction

  task automatic reset_model;
    m = '{TKS_RST_THRESH, TKS_RST_DRIFT, TKS_RST_INTEG, TKS_RST_RECAL, TKS_RST_TIMING,
      TKS_RST_OFFSET, TKS_RST_OPTIONS, TKS_RST_DWELL};
    fl = TKS_RST_FLOOR;
  endtask

  task automatic wr_m(input logic [3:0] ad, input logic [7:0] x);
    i_host.write_reg(ad, x, 1'b0);
    m[ad[2:0]] = x;
    #1;
  endtask

  task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
    i_host.read_reg(ad, d);
    chk("rdata", d, exp);
  endtask

  task automatic chk_cfg;
    chk("neg_thresh", cfg.neg_thresh, m[0][3:0] + 4);
    chk("pos_thresh", cfg.pos_thresh, m[0][7:4] + 4);
    chk("neg_drift", cfg.neg_drift, 8'(m[1][3:0] * 16 + 16));
    chk("pos_drift", cfg.pos_drift, 8'(m[1][7:4] * 16 + 16));
    chk("integ_norm", cfg.detect_integrator_norm, m[2][3:0]);
    chk("burst_off", cfg.burst_disable, m[2][3:0] == 4'h0);
    chk("integ_fast", cfg.detect_integrator_fast, m[2][7:4]);
    chk("recal", cfg.recal_timeout, m[3]);
    chk("recal_inf", cfg.recal_infinite, m[3] == 8'h00);
    if (m[4][3:0] == 4'h6) chk("period", cfg.sample_period_ms, 1000);
    chk("burst_len", cfg.burst_length, (m[4][5:4] + 1) * 16);
    chk("nks", cfg.neighbor_key_suppress, m[4][6]);
    chk("offset", cfg.signal_offset, m[5]);
    chk("hyst", cfg.neg_hyst_pct_x10, (m[6][1:0] + 1) * 125);
    chk("sync", cfg.mains_sync_en, m[6][5]);
    chk("sleep", cfg.sleep_drift, m[6][4:2]);
    chk("sleep_en", cfg.sleep_en, m[6][4:2] != 3'h0);
    chk("mult", cfg.thresh_mult, 1 << m[6][7:6]);
    chk("dwell", cfg.dwell_ns, dwl(m[7][3:0]));
    chk("baud", cfg.baud, bd(m[7][7:4]));
    chk("floor", cfg.signal_floor, fl[10:0]);
    chk("restart", cfg.restart_burst, fl[11]);
    chk("gain_test", cfg.key_gain_test_threshold, fl[15:12] * 4 + 4);
  endtask

  task automatic sample(input logic [10:0] s, input logic exp);
    @(posedge clk);
    key_sig <= s;
    key_sig_vld <= 1'b1;
    @(posedge clk);
    key_sig_vld <= 1'b0;
    key_sig <= ~s;
    #1 chk("sig_low", sig_low, exp);
    @(posedge clk);
    #1 chk("sig_low_end", sig_low, 1'b0);
  endtask

  initial begin
    #50000;
    bad_count++;
    $display("ERROR watchdog expired");
    summarize;
  end

  initial begin
    seed = 14565;
    rst_n = 1'b0;
    key_sig = 11'h000;
    key_sig_vld = 1'b0;
    mains_sync = 1'b1;
    reset_model;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("acq_go_first", acq_go, 1'b0);
    chk_cfg;
    @(posedge clk);
    #1 chk("acq_go_free", acq_go, 1'b1);
    for (v = 0; v < 8; v++) rchk(v[3:0], m[v]);
    // Sweep every code of every table except the gain test table; the sample period is checked at code 6 only
    for (v = 0; v < 16; v++) begin
      wr_m(TKS_OFS_DWELL, {v[3:0], v[3:0]});
      wr_m(TKS_OFS_OPTIONS, {v[1:0], 1'b0, v[2:0], v[1:0]});
      wr_m(TKS_OFS_TIMING, {1'b0, v[0], v[1:0], v[3:0]});
      wr_m(TKS_OFS_DRIFT, {v[3:0], ~v[3:0]});
      chk_cfg;
    end
    for (v = 0; v < 24; v++) begin
      w = $random(seed);
      a = {1'b0, w[2:0]};
      d = w[15:8];
      if (a == TKS_OFS_INTEG && d[7:4] == 4'h0) d[7:4] = 4'h1;
      if (a == TKS_OFS_RECAL && d == TKS_RECAL_ILLEGAL) d = 8'hfe;
      wr_m(a, d);
      rchk(a, d);
      chk_cfg;
    end
    // Forbidden values refused
    i_host.write_reg(TKS_OFS_INTEG, 8'h05, 1'b1);
    rchk(TKS_OFS_INTEG, m[2]);
    i_host.write_reg(TKS_OFS_RECAL, 8'hff, 1'b1);
    rchk(TKS_OFS_RECAL, m[3]);
    rchk(TKS_OFS_STATUS, 8'h02);
    i_host.write_reg(TKS_OFS_STATUS, 8'h02, 1'b0);
    rchk(TKS_OFS_STATUS, 8'h00);
    for (v = 0; v < 3; v++) begin
      w = $random(seed);
      i_host.write_floor(w[15:0]);
      fl = w[15:0];
      #1 chk_cfg;
    end
    i_host.write_reg(TKS_OFS_FLOOR_LO, 8'h00, 1'b0);
    rchk(TKS_OFS_STATUS, 8'h04);
    chk_cfg;
    i_host.write_reg(TKS_OFS_FLOOR_HI, 8'h71, 1'b0);
    fl = 16'h7100;
    #1 chk_cfg;
    sample(11'h0ff, 1'b1);
    sample(11'h100, 1'b0);
    rchk(TKS_OFS_STATUS, 8'h01);
    i_host.write_reg(TKS_OFS_STATUS, 8'h01, 1'b0);
    rchk(TKS_OFS_STATUS, 8'h00);
    // Mains sync gating
    wr_m(TKS_OFS_OPTIONS, 8'h20);
    repeat (3) @(posedge clk);
    #1 chk("acq_idle", acq_go, 1'b0);
    @(posedge clk);
    mains_sync <= 1'b0;
    v = 0;
    while (acq_go !== 1'b1 && v < 8) begin
      @(posedge clk);
      #1 v++;
    end
    chk("acq_pulse", acq_go, 1'b1);
    @(posedge clk);
    #1 chk("acq_once", acq_go, 1'b0);
    mains_sync <= 1'b1;
    wr_m(TKS_OFS_OPTIONS, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("acq_free", acq_go, 1'b1);
    // Unmapped place
    i_host.write_reg(4'hc, 8'h5a, 1'b0);
    rchk(4'hc, 8'h00);
    for (v = 0; v < 8; v++) rchk(v[3:0], m[v]);
    // Reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    reset_model;
    repeat (2) @(posedge clk);
    #1 chk("rdata_rst", rdata, 8'h00);
    chk_cfg;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("acq_go_hold", acq_go, 1'b0);
    @(posedge clk);
    #1 chk("acq_go_back", acq_go, 1'b1);
    chk_cfg;
    summarize;
  end
endmodule
